/* design/vpat_pkg.sv */
// Package of constants and carrier types for the inbound address translator
// Contract
// - Provide 4,096 inbound entries reaching at most 16M bytes of PCI memory.
// - Each entry redirects one 4K remote page onto one chosen 4K PCI page.
// - Inbound entries occupy window offsets 0x8000 to 0xBFFF; outbound below, DMA above.
// - Remote address bits 11..2 pass unchanged into the PCI address; bits 1..0 pass unless an entry swap bit inverts them.
// - Remote address bits 23..12 index the entry; upper remote bits ignored.
// - Selected entry supplies PCI address bits 31..12 and the swap controls.
// - Perform the PCI access at the translated address; return read data remotely.
// - Entry bit 0 set blocks the PCI access and signals a remote bus error.
// - Entry bit 1 byte-swaps word and longword transfer data.
// - Entry bit 2 inverts PCI address bit 1 for word transfers.
// - Entry bit 3 applies byte swapping to byte transfers.
// - Entry bits 4 to 11 are reserved and have no effect.
// - PCI address is entry upper 20 bits joined with remote low 12 bits.
// - Entries are consecutive 32-bit words; offset is 0x8000 plus four times index.
// - Configuration offset 0x18 reports the mapping register window base.
package vpat_pkg;

   localparam int unsigned ENTRY_CNT      = 4096;
   localparam int unsigned IDX_W          = 12;
   localparam int unsigned PAGE_W         = 20;
   localparam int unsigned ENTRY_W        = 24;

   localparam logic [15:0] OUT_TBL_BASE   = 16'h0000;
   localparam logic [15:0] IN_TBL_BASE    = 16'h8000;
   localparam logic [15:0] IN_TBL_LAST    = 16'hBFFF;
   localparam logic [15:0] DMA_TBL_BASE   = 16'hC000;

   localparam int unsigned INV_BIT        = 0;
   localparam int unsigned BSWAP_NB_BIT   = 1;
   localparam int unsigned WSWAP_BIT      = 2;
   localparam int unsigned BSWAP_B_BIT    = 3;
   localparam int unsigned RSVD_LO_BIT    = 4;
   localparam int unsigned RSVD_HI_BIT    = 11;
   localparam int unsigned PAGE_LSB       = 12;
   localparam int unsigned IDX_LSB        = 12;

   localparam logic [7:0]  CFG_MAP_BASE   = 8'h18;
   localparam logic [31:0] CFG_BASE_MASK  = 32'hFFFF0000;
   localparam logic [31:0] CFG_BASE_RST   = 32'h00000000;

   typedef enum logic [1:0] {
      VPAT_SZ_BYTE,
      VPAT_SZ_WORD,
      VPAT_SZ_LONG
   } vpat_size_t;

   typedef struct packed {
      logic       we;
      vpat_size_t size;
      logic [31:0] addr;
      logic [31:0] wdata;
   } vpat_xfer_t;

   typedef struct packed {
      logic [PAGE_W-1:0] page_base_field;
      logic              bswap_byte;
      logic              wswap;
      logic              bswap_nonbyte;
      logic              invalid;
   } vpat_entry_t;

endpackage

/* design/vpat_table_mem.sv */
// Single-port inbound page map memory with registered read data
`timescale 1ns/1ps
module vpat_table_mem
   import vpat_pkg::*;
(
   input  wire logic                clk_i,
   input  wire logic                we_i,
   input  wire logic [IDX_W-1:0]    addr_i,
   input  wire logic [ENTRY_W-1:0]  wdata_i,
   output logic      [ENTRY_W-1:0]  rdata_o
);

   // Contents are not reset: the invalid flag is undefined after power-up
   logic [ENTRY_W-1:0] mem_reg [ENTRY_CNT];

   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem_reg[addr_i] <= wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      rdata_o <= mem_reg[addr_i];
   end

endmodule

/* design/vpat_swap.sv */
// Lane and address swapping for one transfer, as selected by an entry
`timescale 1ns/1ps
module vpat_swap
   import vpat_pkg::*;
(
   input  wire vpat_size_t   size_i,
   input  wire vpat_entry_t  entry_i,
   input  wire logic [1:0]   addr_lo_i,
   input  wire logic [31:0]  data_i,
   output logic      [1:0]   addr_lo_o,
   output logic      [31:0]  data_o
);

   logic [31:0] rev_long;

   // Full byte reversal of a longword
   generate
      for (genvar b = 0; b < 4; b++) begin : g_rev
         assign rev_long[8*b +: 8] = data_i[8*(3-b) +: 8];
      end
   endgenerate

   always_comb begin
      addr_lo_o = addr_lo_i;
      data_o    = data_i;
      case (size_i)
         VPAT_SZ_BYTE: begin
            if (entry_i.bswap_byte) begin
               addr_lo_o[0] = ~addr_lo_i[0];
            end
         end
         VPAT_SZ_WORD: begin
            if (entry_i.wswap) begin
               addr_lo_o[1] = ~addr_lo_i[1];
            end
            if (entry_i.bswap_nonbyte) begin
               data_o = {data_i[31:16], data_i[7:0], data_i[15:8]};
            end
         end
         VPAT_SZ_LONG: begin
            if (entry_i.bswap_nonbyte) begin
               data_o = rev_long;
            end
         end
         default: begin
            data_o = data_i;
         end
      endcase
   end

endmodule

/* design/vpat_translator.sv */
// Inbound remote-to-PCI address translator with page map table and config base
`timescale 1ns/1ps
module vpat_translator
   import vpat_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        arst_n_i,
   // Inbound requests relayed from the remote adapter
   input  wire logic        in_req_i,
   input  wire vpat_xfer_t  in_xfer_i,
   output logic             in_ack_o,
   output logic             in_err_o,
   output logic [31:0]      in_rdata_o,
   // PCI master side
   output logic             pci_req_o,
   output vpat_xfer_t       pci_xfer_o,
   input  wire logic        pci_ack_i,
   input  wire logic [31:0] pci_rdata_i,
   // Mapping register window target
   input  wire logic        map_req_i,
   input  wire logic        map_we_i,
   input  wire logic [15:0] map_off_i,
   input  wire logic [31:0] map_wdata_i,
   output logic             map_ack_o,
   output logic [31:0]      map_rdata_o,
   // Configuration space target
   input  wire logic        cfg_req_i,
   input  wire logic        cfg_we_i,
   input  wire logic [7:0]  cfg_off_i,
   input  wire logic [31:0] cfg_wdata_i,
   output logic             cfg_ack_o,
   output logic [31:0]      cfg_rdata_o,
   output logic [31:0]      map_base_o
);

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_LOOKUP,
      ST_PCI,
      ST_MAP_RD,
      ST_MAP_DONE
   } vpat_state_t;

   function automatic logic in_table(input logic [15:0] off);
      return (off >= IN_TBL_BASE) && (off <= IN_TBL_LAST);
   endfunction

   function automatic logic [IDX_W-1:0] off_to_idx(input logic [15:0] off);
      logic [15:0] rel;
      rel = off - IN_TBL_BASE;
      return rel[IDX_W+1:2];
   endfunction

   function automatic logic [31:0] entry_to_word(input logic [ENTRY_W-1:0] e);
      return {e[ENTRY_W-1:4], 8'h00, e[3:0]};
   endfunction

   vpat_state_t         state_reg;
   vpat_state_t         state_next;
   vpat_xfer_t          held_reg;
   logic [15:0]         map_off_reg;

   logic                mem_we;
   logic [IDX_W-1:0]    mem_addr;
   logic [ENTRY_W-1:0]  mem_wdata;
   logic [ENTRY_W-1:0]  mem_rdata;
   vpat_entry_t         cur_entry;

   logic [1:0]          sw_addr_lo;
   logic [31:0]         sw_wdata;
   logic [31:0]         sw_rdata;
   vpat_entry_t         held_entry_reg;

   logic                take_in;
   logic                take_map;
   logic                map_wr_hit;

   assign take_in    = (state_reg == ST_IDLE) && in_req_i;
   assign take_map   = (state_reg == ST_IDLE) && !in_req_i && map_req_i;
   assign map_wr_hit = take_map && map_we_i && in_table(map_off_i);
   assign cur_entry  = vpat_entry_t'(mem_rdata);

   // Table port: an inbound lookup has priority over software in the same cycle
   always_comb begin
      mem_we    = 1'b0;
      mem_addr  = '0;
      mem_wdata = '0;
      if (take_in) begin
         mem_addr = in_xfer_i.addr[IDX_LSB +: IDX_W];
      end else if (take_map) begin
         mem_addr = off_to_idx(map_off_i);
         if (map_wr_hit) begin
            mem_we    = 1'b1;
            // Reserved bits are dropped so they can never steer translation
            mem_wdata = {map_wdata_i[31:PAGE_LSB], map_wdata_i[3:0]};
         end
      end
   end

   vpat_table_mem u_table (
      .clk_i   (clk_i),
      .we_i    (mem_we),
      .addr_i  (mem_addr),
      .wdata_i (mem_wdata),
      .rdata_o (mem_rdata)
   );

   // Outbound address and write data shaped by the fresh entry
   vpat_swap u_swap_out (
      .size_i    (held_reg.size),
      .entry_i   (cur_entry),
      .addr_lo_i (held_reg.addr[1:0]),
      .data_i    (held_reg.wdata),
      .addr_lo_o (sw_addr_lo),
      .data_o    (sw_wdata)
   );

   // Read data is swapped back with the entry captured at issue
   vpat_swap u_swap_rd (
      .size_i    (held_reg.size),
      .entry_i   (held_entry_reg),
      .addr_lo_i (held_reg.addr[1:0]),
      .data_i    (pci_rdata_i),
      .addr_lo_o (),
      .data_o    (sw_rdata)
   );

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (take_in) begin
               state_next = ST_LOOKUP;
            end else if (take_map && !map_we_i) begin
               state_next = ST_MAP_RD;
            end else if (take_map) begin
               state_next = ST_MAP_DONE;
            end
         end
         ST_LOOKUP: begin
            if (cur_entry.invalid) begin
               state_next = ST_IDLE;
            end else begin
               state_next = ST_PCI;
            end
         end
         ST_PCI: begin
            if (pci_ack_i) begin
               state_next = ST_IDLE;
            end
         end
         ST_MAP_RD: begin
            state_next = ST_MAP_DONE;
         end
         ST_MAP_DONE: begin
            state_next = ST_IDLE;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Capture of the pending inbound request
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         held_reg <= '0;
      end else if (take_in) begin
         held_reg <= in_xfer_i;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         map_off_reg <= '0;
      end else if (take_map) begin
         map_off_reg <= map_off_i;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         held_entry_reg <= '0;
      end else if (state_reg == ST_LOOKUP) begin
         held_entry_reg <= cur_entry;
      end
   end

   // PCI master cycle issue
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pci_req_o  <= 1'b0;
         pci_xfer_o <= '0;
      end else begin
         pci_req_o <= 1'b0;
         if ((state_reg == ST_LOOKUP) && !cur_entry.invalid) begin
            pci_req_o        <= 1'b1;
            pci_xfer_o.we    <= held_reg.we;
            pci_xfer_o.size  <= held_reg.size;
            pci_xfer_o.wdata <= sw_wdata;
            pci_xfer_o.addr  <= {cur_entry.page_base_field, held_reg.addr[11:2], sw_addr_lo};
         end
      end
   end

   // Answer toward the remote side
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         in_ack_o   <= 1'b0;
         in_err_o   <= 1'b0;
         in_rdata_o <= '0;
      end else begin
         in_ack_o <= 1'b0;
         in_err_o <= 1'b0;
         if ((state_reg == ST_LOOKUP) && cur_entry.invalid) begin
            in_ack_o <= 1'b1;
            in_err_o <= 1'b1;
         end else if ((state_reg == ST_PCI) && pci_ack_i) begin
            in_ack_o <= 1'b1;
            if (!held_reg.we) begin
               in_rdata_o <= sw_rdata;
            end
         end
      end
   end

   // Mapping window answers; outbound and DMA ranges read zero and drop writes
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         map_ack_o   <= 1'b0;
         map_rdata_o <= '0;
      end else begin
         map_ack_o <= 1'b0;
         if (state_reg == ST_MAP_DONE) begin
            map_ack_o <= 1'b1;
         end
         if (state_reg == ST_MAP_RD) begin
            if (in_table(map_off_reg)) begin
               map_rdata_o <= entry_to_word(mem_rdata);
            end else begin
               map_rdata_o <= '0;
            end
         end
      end
   end

   // Configuration base of the mapping window
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         map_base_o <= CFG_BASE_RST;
      end else if (cfg_req_i && cfg_we_i && (cfg_off_i == CFG_MAP_BASE)) begin
         map_base_o <= cfg_wdata_i & CFG_BASE_MASK;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cfg_ack_o   <= 1'b0;
         cfg_rdata_o <= '0;
      end else begin
         cfg_ack_o <= cfg_req_i;
         if (cfg_req_i && !cfg_we_i) begin
            if (cfg_off_i == CFG_MAP_BASE) begin
               cfg_rdata_o <= map_base_o;
            end else begin
               cfg_rdata_o <= '0;
            end
         end
      end
   end

endmodule

/* bench/vpat_translator_properties.sv */
// Port timing checker for the inbound address translator
`timescale 1ns/1ps
module vpat_translator_properties
   import vpat_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        arst_n_i,
   input wire logic        in_req_i,
   input wire vpat_xfer_t  in_xfer_i,
   input wire logic        in_ack_o,
   input wire logic        in_err_o,
   input wire logic        pci_req_o,
   input wire vpat_xfer_t  pci_xfer_o,
   input wire logic        pci_ack_i,
   input wire logic        map_req_i,
   input wire logic        map_we_i,
   input wire logic        map_ack_o,
   input wire logic        cfg_req_i,
   input wire logic        cfg_we_i,
   input wire logic [7:0]  cfg_off_i,
   input wire logic [31:0] cfg_wdata_i,
   input wire logic [31:0] map_base_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   sequence s_map_take(w);
      map_req_i && map_we_i == w && !in_req_i;
   endsequence
   sequence s_base_wr;
      cfg_req_i && cfg_we_i && cfg_off_i == CFG_MAP_BASE;
   endsequence
   chk_err_no_pci: assert property (in_err_o |-> in_ack_o && !pci_req_o && $past(in_req_i, 2))
      else $error("error flag timing wrong");
   chk_low_bits: assert property (pci_req_o |-> $past(in_req_i, 2) &&
      pci_xfer_o.addr[11:2] == $past(in_xfer_i.addr[11:2], 2))
      else $error("pci offset bits differ");
   chk_kind_kept: assert property (pci_req_o |-> pci_xfer_o.we == $past(in_xfer_i.we, 2) &&
      pci_xfer_o.size == $past(in_xfer_i.size, 2))
      else $error("pci direction or size differs");
   chk_ack_after_pci: assert property (pci_ack_i |=> in_ack_o && !in_err_o)
      else $error("inbound ack missing");
   chk_single_issue: assert property (pci_req_o |=> !pci_req_o [*3])
      else $error("pci issue too soon");
   chk_map_wr_ack: assert property (s_map_take(1'b1) |-> ##2 map_ack_o)
      else $error("map write ack late");
   chk_map_rd_ack: assert property (s_map_take(1'b0) |-> ##3 map_ack_o)
      else $error("map read ack late");
   chk_base_masked: assert property (s_base_wr |=> map_base_o == ($past(cfg_wdata_i) & CFG_BASE_MASK))
      else $error("map base value wrong");
endmodule
bind vpat_translator vpat_translator_properties chk_u (.clk_i, .arst_n_i, .in_req_i, .in_xfer_i, .in_ack_o,
   .in_err_o, .pci_req_o, .pci_xfer_o, .pci_ack_i, .map_req_i, .map_we_i, .map_ack_o, .cfg_req_i, .cfg_we_i,
   .cfg_off_i, .cfg_wdata_i, .map_base_o);

/* bench/vpat_remote_model.sv */
// Remote adapter model relaying remote master accesses
`timescale 1ns/1ps
module vpat_remote_model
   import vpat_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        ack_i,
   input  wire logic        err_i,
   input  wire logic [31:0] rdata_i,
   output logic             req_o,
   output vpat_xfer_t       xfer_o
);
   initial begin
      req_o = 1'b0;
      xfer_o = '0;
   end
   // Whole remote address goes over, wherever the caller placed its window
   task automatic access(input vpat_xfer_t x, output logic err, output logic [31:0] rd,
                         output logic ok);
      int n;
      req_o = 1'b1;
      xfer_o = x;
      @(posedge clk_i);
      #1;
      req_o = 1'b0;
      xfer_o = ~x;
      for (n = 0; n < 40 && ack_i !== 1'b1; n++) begin
         @(posedge clk_i);
         #1;
      end
      err = err_i;
      rd = rdata_i;
      ok = (ack_i === 1'b1);
   endtask
endmodule

/* bench/tb_top.sv */
// Self-checking bench for the inbound address translator
`timescale 1ns/1ps
module tb_top
   import vpat_pkg::*;
;
   logic        clk_i, arst_n_i, in_req_i, in_ack_o, in_err_o, pci_req_o, map_ack_o, cfg_ack_o, rerr, rok;
   logic        pci_ack_i = 1'b0, map_req_i = 1'b0, map_we_i = 1'b0, cfg_req_i = 1'b0, cfg_we_i = 1'b0;
   logic [15:0] map_off_i = 16'h0;
   logic [7:0]  cfg_off_i = 8'h0;
   logic [31:0] pci_rdata_i = 32'h0, map_wdata_i = 32'h0, cfg_wdata_i = 32'h0, rpat = 32'h0;
   logic [31:0] in_rdata_o, map_rdata_o, cfg_rdata_o, map_base_o, rrd;
   vpat_xfer_t  in_xfer_i, pci_xfer_o, seen;
   int          errors = 0, checks = 0, pdly = 1, pcnt = 0;

   vpat_translator dut_u (.clk_i, .arst_n_i, .in_req_i, .in_xfer_i, .in_ack_o, .in_err_o, .in_rdata_o, .pci_req_o,
      .pci_xfer_o, .pci_ack_i, .pci_rdata_i, .map_req_i, .map_we_i, .map_off_i, .map_wdata_i, .map_ack_o,
      .map_rdata_o, .cfg_req_i, .cfg_we_i, .cfg_off_i, .cfg_wdata_i, .cfg_ack_o, .cfg_rdata_o, .map_base_o);
   vpat_remote_model rem_u (.clk_i, .ack_i(in_ack_o), .err_i(in_err_o), .rdata_i(in_rdata_o), .req_o(in_req_i),
      .xfer_o(in_xfer_i));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // PCI target: answers each issue after pdly cycles, data lines toggle when idle
   initial forever begin
      @(posedge clk_i);
      #1;
      if (pci_req_o === 1'b1) begin
         pcnt++;
         seen = pci_xfer_o;
         #(10 * pdly);
         pci_ack_i = 1'b1;
         pci_rdata_i = rpat;
         @(posedge clk_i);
         #1;
         pci_ack_i = 1'b0;
         pci_rdata_i = ~rpat;
      end
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic complete_run;
      if (errors == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic map_acc(input logic we, input logic [15:0] off, input logic [31:0] wd, output logic [31:0] rd);
      int n;
      map_req_i = 1'b1;
      map_we_i = we;
      map_off_i = off;
      map_wdata_i = wd;
      @(posedge clk_i);
      #1;
      map_req_i = 1'b0;
      map_wdata_i = ~wd;
      for (n = 0; n < 20 && map_ack_o !== 1'b1; n++) begin
         @(posedge clk_i);
         #1;
      end
      check("map ack", 32'h1, {31'h0, map_ack_o});
      rd = map_rdata_o;
   endtask

   task automatic put(input logic [11:0] idx, input logic [31:0] v);
      logic [31:0] d;
      map_acc(1'b1, IN_TBL_BASE + {2'b00, idx, 2'b00}, v, d);
   endtask

   task automatic rem(input logic we, input vpat_size_t sz, input logic [31:0] a, input logic [31:0] wd);
      rem_u.access('{we, sz, a, wd}, rerr, rrd, rok);
      check("remote ack", 32'h1, {31'h0, rok});
   endtask

   task automatic cfg_acc(input logic we, input logic [7:0] off, input logic [31:0] wd);
      cfg_req_i = 1'b1;
      cfg_we_i = we;
      cfg_off_i = off;
      cfg_wdata_i = wd;
      @(posedge clk_i);
      #1;
      cfg_req_i = 1'b0;
      check("cfg ack", 32'h1, {31'h0, cfg_ack_o});
      @(posedge clk_i);
      #1;
   endtask

   task automatic t_table;
      logic [31:0] d;
      put(12'h000, 32'hFFFFFFFF);
      put(12'hFFF, 32'h5A5A5AF5);
      map_acc(1'b1, 16'h7FFC, 32'hFFFFFFFF, d);
      map_acc(1'b0, IN_TBL_BASE, 32'h0, d);
      check("first entry", 32'hFFFFF00F, d);
      map_acc(1'b0, IN_TBL_LAST - 16'h3, 32'h0, d);
      check("last entry", 32'h5A5A5005, d);
      map_acc(1'b0, 16'h7FFC, 32'h0, d);
      check("outbound slot", 32'h0, d);
   endtask

   task automatic t_xlate;
      put(12'h400, 32'h12345FF0);
      rem(1'b1, VPAT_SZ_LONG, 32'hFF400ABC, 32'hCAFEF00D);
      check("wr addr", 32'h12345ABC, seen.addr);
      check("wr data", 32'hCAFEF00D, seen.wdata);
      check("wr err", 32'h0, {31'h0, rerr});
      pdly = 6;
      rpat = 32'h89ABCDEF;
      rem(1'b0, VPAT_SZ_LONG, 32'h00400FFC, 32'h0);
      check("rd data", 32'h89ABCDEF, rrd);
      check("rd addr", 32'h12345FFC, seen.addr);
      pdly = 1;
   endtask

   task automatic t_swap;
      put(12'h001, 32'h0000200E);
      rpat = 32'h11223344;
      rem(1'b0, VPAT_SZ_LONG, 32'h00001010, 32'h0);
      check("long swap", 32'h44332211, rrd);
      rem(1'b1, VPAT_SZ_WORD, 32'h00001012, 32'h00001234);
      check("word addr", 32'h00002010, seen.addr);
      check("word swap", 32'h3412, {16'h0, seen.wdata[15:0]});
      rem(1'b1, VPAT_SZ_BYTE, 32'h00001013, 32'h000000A5);
      check("byte addr", 32'h00002012, seen.addr);
   endtask

   task automatic t_invalid;
      int c;
      put(12'h002, 32'h00003001);
      c = pcnt;
      rem(1'b0, VPAT_SZ_LONG, 32'h00002000, 32'h0);
      check("bus error", 32'h1, {31'h0, rerr});
      check("pci count", c, pcnt);
      put(12'h002, 32'h00003000);
      rem(1'b0, VPAT_SZ_LONG, 32'h00002004, 32'h0);
      check("valid again", 32'h00003004, seen.addr);
   endtask

   task automatic t_cfg;
      cfg_acc(1'b1, CFG_MAP_BASE, 32'hA5A51234);
      check("map base", 32'hA5A50000, map_base_o);
      cfg_acc(1'b0, CFG_MAP_BASE, 32'h0);
      check("cfg read", 32'hA5A50000, cfg_rdata_o);
      cfg_acc(1'b0, 8'h1C, 32'h0);
      check("cfg other", 32'h0, cfg_rdata_o);
      // Mid-run reset must clear the base and the held read data
      arst_n_i = 1'b0;
      #1;
      check("base cleared", CFG_BASE_RST, map_base_o);
      check("rdata cleared", 32'h0, in_rdata_o);
      @(posedge clk_i);
      #1;
      arst_n_i = 1'b1;
   endtask

   initial begin
      arst_n_i = 1'b0;
      repeat (5) @(posedge clk_i);
      #1;
      arst_n_i = 1'b1;
      check("base reset", CFG_BASE_RST, map_base_o);
      t_table;
      t_xlate;
      t_swap;
      t_invalid;
      t_cfg;
      complete_run;
   end

   initial begin
      #200000;
      errors++;
      complete_run;
   end
endmodule
